// ===== core/prot_pkg.sv
package prot_pkg;

	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam int          PHASES          = 3;

	localparam logic [7:0]  CTRL_OFS        = 8'h00;
	localparam logic [7:0]  STATUS_OFS      = 8'h04;
	localparam logic [7:0]  CMD_OFS         = 8'h08;
	localparam logic [7:0]  STAGE_STAT_OFS  = 8'h0c;
	localparam logic [7:0]  STAGE_OFS       = 8'h10;
	localparam logic [5:0]  STAGE_WORD      = 6'h04;

	localparam int          CTRL_FUNC_BIT   = 0;
	localparam int          CTRL_EXBLK_BIT  = 1;
	localparam int          CTRL_TCPERM_BIT = 2;
	localparam int          CTRL_TCEXT_BIT  = 3;
	localparam int          CTRL_W          = 4;
	localparam logic [3:0]  CTRL_RST        = 4'h0;

	localparam int          CFG_FUNC_BIT    = 0;
	localparam int          CFG_SUPERV_BIT  = 1;
	localparam int          CFG_TCPERM_BIT  = 2;
	localparam int          CFG_TCEXT_BIT   = 3;
	localparam int          CFG_GROUND_BIT  = 4;
	localparam int          CFG_PHSEL_BIT   = 5;
	localparam int          CFG_ROUTE_LSB   = 8;
	localparam int          ROUTE_W         = 8;
	localparam int          CFG_DELAY_LSB   = 16;
	localparam int          DELAY_W         = 16;
	localparam logic [31:0] CFG_MASK        = 32'hffff_ff3f;
	localparam logic [31:0] CFG_RST         = 32'h0000_0000;

	localparam int          ST_ALARM_BIT    = 0;
	localparam int          ST_TRIP_BIT     = 1;
	localparam int          ST_GROUND_BIT   = 2;
	localparam int          ST_PHALM_LSB    = 4;
	localparam int          ST_PHTRIP_LSB   = 8;
	localparam int          ST_BLOCKED_BIT  = 16;
	localparam int          ST_CMDBLK_BIT   = 17;

	localparam int          SST_TRIP_LSB    = 8;
	localparam int          SST_CMD_LSB     = 16;

endpackage

// ===== core/stage_if.sv
`timescale 1ns/100ps
interface stage_if;
	logic [31:0] cfg;
	logic [2:0]  fault;
	logic        block_in;
	logic        master_en;
	logic        cmd_block;
	logic        alarm;
	logic        trip;
	logic [2:0]  ph_alarm;
	logic [2:0]  ph_trip;
	logic        ground;
	logic        cmd;

	modport stage (
		input  cfg, fault, block_in, master_en, cmd_block,
		output alarm, trip, ph_alarm, ph_trip, ground, cmd
	);
	modport master (
		output cfg, fault, block_in, master_en, cmd_block,
		input  alarm, trip, ph_alarm, ph_trip, ground, cmd
	);
endinterface

// ===== core/prot_stage.sv
`timescale 1ns/100ps
module prot_stage (
	input  wire logic  clk,
	input  wire logic  reset,
	stage_if.stage     p
);
	typedef struct packed {
		logic [prot_pkg::DELAY_W-1:0] cnt;
		logic                         alarm;
		logic                         trip;
		logic [2:0]                   ph_alarm;
		logic [2:0]                   ph_trip;
		logic                         ground;
		logic                         cmd;
	} stage_state_type;

	stage_state_type              r;
	stage_state_type              r_nxt;
	logic                         active;
	logic                         crit;
	logic                         rep;
	logic                         blk;
	logic                         phsel;
	logic [2:0]                   sel;
	logic [prot_pkg::DELAY_W-1:0] dly;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	assign dly    = p.cfg[prot_pkg::CFG_DELAY_LSB +: prot_pkg::DELAY_W];
	assign phsel  = p.cfg[prot_pkg::CFG_PHSEL_BIT];
	// Off module or stopped master: stage is held idle
	assign active = p.cfg[prot_pkg::CFG_FUNC_BIT] & p.master_en;
	// Non-selective stages look at lane 0 only
	assign sel    = phsel ? p.fault : {2'b00, p.fault[0]};
	assign crit   = |sel;
	// Supervision stages report nothing
	assign rep    = ~p.cfg[prot_pkg::CFG_SUPERV_BIT];
	// Own and master command blocks
	assign blk    = p.cmd_block | p.cfg[prot_pkg::CFG_TCPERM_BIT]
		| (p.cfg[prot_pkg::CFG_TCEXT_BIT] & p.block_in);

	always_comb begin
		r_nxt = '0;
		if (active && crit) begin
			// Alarm at once on the criterion
			r_nxt.alarm    = rep;
			r_nxt.ph_alarm = phsel ? (sel & {3{rep}}) : 3'b000;
			r_nxt.ground   = rep & p.cfg[prot_pkg::CFG_GROUND_BIT];
			r_nxt.cnt      = (r.cnt == dly) ? r.cnt : r.cnt + 1'b1;
			// Trip only once the timer ran out uninterrupted
			if (r.cnt == dly) begin
				r_nxt.trip    = rep;
				r_nxt.ph_trip = phsel ? (sel & {3{rep}}) : 3'b000;
				r_nxt.cmd     = rep & ~blk;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign p.alarm    = r.alarm;
	assign p.trip     = r.trip;
	assign p.ph_alarm = r.ph_alarm;
	assign p.ph_trip  = r.ph_trip;
	assign p.ground   = r.ground;
	assign p.cmd      = r.cmd;

	sequence crit_lost;
		!(active && crit);
	endsequence

	trip_reset_a: assert property (crit_lost |=> !r.trip && r.cnt == '0)
		else $error("trip survived loss of criterion");
	trip_delay_a: assert property (r.trip |-> $past(r.cnt) == dly)
		else $error("trip before delay elapsed");
	superv_quiet_a: assert property (
		p.cfg[prot_pkg::CFG_SUPERV_BIT] && $past(p.cfg[prot_pkg::CFG_SUPERV_BIT])
		|-> !r.alarm && !r.trip && !r.cmd && r.ph_alarm == 3'b000)
		else $error("supervision stage reported");
	cmd_block_a: assert property ($past(blk) |-> !r.cmd)
		else $error("blocked stage issued command");
endmodule

// ===== core/prot_master.sv
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
// Contract
// - Global function off disables every stage, no alarm, trip or command.
// - Permitted external block inputs block all protection while either is true.
// - Master command block setting suppresses all trip commands permanently.
// - Permitted external command block input suppresses commands while true.
// - Each stage raises its alarm as soon as it sees its fault.
// - General alarm is the OR of all contributing stage alarms.
// - A stage trips only if its fault persists past its delay.
// - General trip is the OR of all contributing stage trips.
// - A tripping stage issues a command unless its command is blocked.
// - Commands and their blocking exist only for non supervision stages.
// - Each phase alarm output ORs the phase alarms of all stages.
// - Each phase trip output ORs the phase trips of all stages.
// - Supervision stages feed nothing to the master and never open breakers.
// - Alarms from ground stages also raise the master ground alarm.
// - A phase selective stage flags each faulty phase separately.
// - Phase selective trips raise the matching per phase master trips.
// - Commands open only breakers they are routed to; routing picks breaker.
// - Each module has its own on or off setting; off means silent.
// - A stage's own command block setting suppresses its command permanently.
// - Permitted stage block signal blocks that stage's command while active.
module prot_master #(
	parameter int NUM_STAGES   = 4,
	parameter int NUM_BREAKERS = 2
) (
	input  wire logic                    CORE_CLK,
	input  wire logic                    RESET,
	input  wire logic                    PSEL,
	input  wire logic                    PENABLE,
	input  wire logic                    PWRITE,
	input  wire logic [7:0]              PADDR,
	input  wire logic [31:0]             PWDATA,
	output logic      [31:0]             PRDATA,
	output logic                         PREADY,
	output logic                         PSLVERR,
	input  wire logic                    EXT_BLOCK_IN_A,
	input  wire logic                    EXT_BLOCK_IN_B,
	input  wire logic                    TRIP_CMD_EXT_BLOCK_IN,
	input  wire logic [3*NUM_STAGES-1:0] STAGE_FAULT_IN,
	input  wire logic [NUM_STAGES-1:0]   STAGE_BLOCK_IN,
	output logic                         GENERAL_ALARM,
	output logic                         GENERAL_TRIP,
	output logic                         GROUND_ALARM,
	output logic      [2:0]              PHASE_ALARM,
	output logic      [2:0]              MASTER_PHASE_TRIP,
	output logic      [NUM_STAGES-1:0]   BREAKER_OPEN_REQUEST,
	output logic      [NUM_BREAKERS-1:0] BREAKER_TRIP
);
	localparam int NS = NUM_STAGES;
	localparam int NB = NUM_BREAKERS;

	typedef struct packed {
		logic                  blk_a_s1;
		logic                  blk_a_s2;
		logic                  blk_b_s1;
		logic                  blk_b_s2;
		logic                  tcb_s1;
		logic                  tcb_s2;
		logic [NS-1:0][2:0]    fault_s1;
		logic [NS-1:0][2:0]    fault_s2;
		logic [NS-1:0]         sblk_s1;
		logic [NS-1:0]         sblk_s2;
		logic [prot_pkg::CTRL_W-1:0] ctrl;
		logic [NS-1:0][31:0]   cfg;
		logic                  gen_alarm;
		logic                  gen_trip;
		logic                  ground;
		logic [2:0]            ph_alarm;
		logic [2:0]            ph_trip;
		logic [NS-1:0]         open_req;
		logic [NB-1:0]         brk;
		logic [31:0]           prdata;
		logic                  pready;
		logic                  pslverr;
	} master_state_type;

	master_state_type   r;
	master_state_type   r_nxt;
	logic               master_ok;
	logic               cmd_blk;
	logic [NS-1:0]      st_alarm;
	logic [NS-1:0]      st_trip;
	logic [NS-1:0]      st_ground;
	logic [NS-1:0]      st_cmd;
	logic [NS-1:0][2:0] st_ph_alarm;
	logic [NS-1:0][2:0] st_ph_trip;
	logic [2:0]         ph_alarm_any;
	logic [2:0]         ph_trip_any;
	logic [NB-1:0]      brk_any;
	logic [5:0]         word;
	logic [5:0]         sidx;
	logic               stage_hit;
	logic               access;
	logic               done;

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	// Master gate from function and synchronised block pins
	assign master_ok = r.ctrl[prot_pkg::CTRL_FUNC_BIT]
		& ~(r.ctrl[prot_pkg::CTRL_EXBLK_BIT] & (r.blk_a_s2 | r.blk_b_s2));
	// Command block for all stages
	assign cmd_blk = r.ctrl[prot_pkg::CTRL_TCPERM_BIT]
		| (r.ctrl[prot_pkg::CTRL_TCEXT_BIT] & r.tcb_s2);

	for (genvar i = 0; i < NS; i++) begin : gs
		stage_if sif ();
		assign sif.cfg        = r.cfg[i];
		assign sif.fault      = r.fault_s2[i];
		assign sif.block_in   = r.sblk_s2[i];
		assign sif.master_en  = master_ok;
		assign sif.cmd_block  = cmd_blk;
		assign st_alarm[i]    = sif.alarm;
		assign st_trip[i]     = sif.trip;
		assign st_ground[i]   = sif.ground;
		assign st_cmd[i]      = sif.cmd;
		assign st_ph_alarm[i] = sif.ph_alarm;
		assign st_ph_trip[i]  = sif.ph_trip;
		prot_stage u_stage (
			.clk   (CORE_CLK),
			.reset (RESET),
			.p     (sif.stage)
		);
	end

	assign word      = PADDR[7:2];
	assign sidx      = word - prot_pkg::STAGE_WORD;
	assign stage_hit = (PADDR >= prot_pkg::STAGE_OFS) && (sidx < 6'(NS));
	// One wait state: data is registered in the first access cycle
	assign access    = PSEL & PENABLE & ~r.pready;
	assign done      = PSEL & PENABLE & r.pready;

	always_comb begin
		r_nxt = r;
		ph_alarm_any = 3'b000;
		ph_trip_any  = 3'b000;
		brk_any      = '0;

		r_nxt.blk_a_s1 = EXT_BLOCK_IN_A;
		r_nxt.blk_a_s2 = r.blk_a_s1;
		r_nxt.blk_b_s1 = EXT_BLOCK_IN_B;
		r_nxt.blk_b_s2 = r.blk_b_s1;
		r_nxt.tcb_s1   = TRIP_CMD_EXT_BLOCK_IN;
		r_nxt.tcb_s2   = r.tcb_s1;
		r_nxt.fault_s1 = STAGE_FAULT_IN;
		r_nxt.fault_s2 = r.fault_s1;
		r_nxt.sblk_s1  = STAGE_BLOCK_IN;
		r_nxt.sblk_s2  = r.sblk_s1;

		for (int i = 0; i < NS; i++) begin
			ph_alarm_any = ph_alarm_any | st_ph_alarm[i];
			ph_trip_any  = ph_trip_any | st_ph_trip[i];
			for (int b = 0; b < NB; b++) begin
				// Routing mask selects the breaker
				brk_any[b] = brk_any[b]
					| (st_cmd[i] & r.cfg[i][prot_pkg::CFG_ROUTE_LSB + b]);
			end
		end

		// Master outputs gated once more so a stop is seen at once
		r_nxt.gen_alarm = master_ok & (|st_alarm);
		r_nxt.gen_trip  = master_ok & (|st_trip);
		r_nxt.ground    = master_ok & (|st_ground);
		r_nxt.ph_alarm  = ph_alarm_any & {3{master_ok}};
		r_nxt.ph_trip   = ph_trip_any & {3{master_ok}};
		r_nxt.open_req  = st_cmd & {NS{master_ok & ~cmd_blk}};
		r_nxt.brk       = brk_any & {NB{master_ok & ~cmd_blk}};

		r_nxt.pready  = access;
		r_nxt.pslverr = 1'b0;
		if (access) begin
			r_nxt.prdata = 32'h0000_0000;
			if (PADDR[1:0] != 2'b00) begin
				r_nxt.pslverr = 1'b1;
			end else if (PADDR == prot_pkg::CTRL_OFS) begin
				r_nxt.prdata[prot_pkg::CTRL_W-1:0] = r.ctrl;
			end else if (PADDR == prot_pkg::STATUS_OFS) begin
				r_nxt.prdata[prot_pkg::ST_ALARM_BIT]   = r.gen_alarm;
				r_nxt.prdata[prot_pkg::ST_TRIP_BIT]    = r.gen_trip;
				r_nxt.prdata[prot_pkg::ST_GROUND_BIT]  = r.ground;
				r_nxt.prdata[prot_pkg::ST_PHALM_LSB +: 3]  = r.ph_alarm;
				r_nxt.prdata[prot_pkg::ST_PHTRIP_LSB +: 3] = r.ph_trip;
				r_nxt.prdata[prot_pkg::ST_BLOCKED_BIT] = ~master_ok;
				r_nxt.prdata[prot_pkg::ST_CMDBLK_BIT]  = cmd_blk;
			end else if (PADDR == prot_pkg::CMD_OFS) begin
				r_nxt.prdata[NS-1:0] = r.open_req;
				r_nxt.prdata[prot_pkg::ROUTE_W +: NB] = r.brk;
			end else if (PADDR == prot_pkg::STAGE_STAT_OFS) begin
				r_nxt.prdata[NS-1:0] = st_alarm;
				r_nxt.prdata[prot_pkg::SST_TRIP_LSB +: NS] = st_trip;
				r_nxt.prdata[prot_pkg::SST_CMD_LSB +: NS]  = st_cmd;
			end else if (stage_hit) begin
				for (int i = 0; i < NS; i++) begin
					if (sidx == 6'(i)) begin
						r_nxt.prdata = r.cfg[i];
					end
				end
			end else begin
				r_nxt.pslverr = 1'b1;
			end
		end

		// Writes land at the completing edge; read-only words ignore them
		if (done && PWRITE && !r.pslverr) begin
			if (PADDR == prot_pkg::CTRL_OFS) begin
				r_nxt.ctrl = PWDATA[prot_pkg::CTRL_W-1:0];
			end else if (stage_hit) begin
				for (int i = 0; i < NS; i++) begin
					if (sidx == 6'(i)) begin
						r_nxt.cfg[i] = PWDATA & prot_pkg::CFG_MASK;
					end
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			r <= '0;
			r.ctrl <= prot_pkg::CTRL_RST;
			r.cfg <= {NS{prot_pkg::CFG_RST}};
		end else begin
			r <= r_nxt;
		end
	end

	assign PRDATA               = r.prdata;
	assign PREADY               = r.pready;
	assign PSLVERR              = r.pslverr;
	assign GENERAL_ALARM        = r.gen_alarm;
	assign GENERAL_TRIP         = r.gen_trip;
	assign GROUND_ALARM         = r.ground;
	assign PHASE_ALARM          = r.ph_alarm;
	assign MASTER_PHASE_TRIP    = r.ph_trip;
	assign BREAKER_OPEN_REQUEST = r.open_req;
	assign BREAKER_TRIP         = r.brk;

	sequence blk_a_held;
		(EXT_BLOCK_IN_A && r.ctrl[prot_pkg::CTRL_EXBLK_BIT]) [*3];
	endsequence

	sequence tcb_held;
		(TRIP_CMD_EXT_BLOCK_IN && r.ctrl[prot_pkg::CTRL_TCEXT_BIT]) [*4];
	endsequence

	fn_off_a: assert property (
		!r.ctrl[prot_pkg::CTRL_FUNC_BIT]
		|=> BREAKER_TRIP == '0 && BREAKER_OPEN_REQUEST == '0 && !GENERAL_TRIP)
		else $error("output while function off");
	ext_block_a: assert property (blk_a_held
		|=> !GENERAL_ALARM && !GENERAL_TRIP && BREAKER_TRIP == '0)
		else $error("protection not blocked by input");
	perm_cmd_a: assert property (
		r.ctrl[prot_pkg::CTRL_TCPERM_BIT]
		|=> BREAKER_OPEN_REQUEST == '0 && BREAKER_TRIP == '0)
		else $error("command despite permanent block");
	ext_cmd_a: assert property (tcb_held
		|=> BREAKER_OPEN_REQUEST == '0 && BREAKER_TRIP == '0)
		else $error("command despite external block");
	alarm_or_a: assert property (
		master_ok && (|st_alarm) |=> GENERAL_ALARM)
		else $error("general alarm missing");
	alarm_none_a: assert property (!(|st_alarm) |=> !GENERAL_ALARM)
		else $error("general alarm without stage");
	trip_or_a: assert property (
		master_ok && (|st_trip) |=> GENERAL_TRIP ##0 $past(st_trip) != '0)
		else $error("general trip mismatch");
	phase_alarm_a: assert property (
		master_ok |=> PHASE_ALARM == $past(ph_alarm_any))
		else $error("phase alarm mismatch");
	phase_trip_a: assert property (
		$rose(MASTER_PHASE_TRIP[0]) |-> $past(ph_trip_any[0] && master_ok))
		else $error("phase trip without stage");
	ground_alarm_a: assert property (
		GROUND_ALARM |-> GENERAL_ALARM)
		else $error("ground alarm without general alarm");
	route_a: assert property (
		BREAKER_TRIP[0] |-> $past(brk_any[0]) && BREAKER_OPEN_REQUEST != '0)
		else $error("breaker opened without routed command");
	quiet_a: assert property (!master_ok |=> !GENERAL_ALARM && !GROUND_ALARM
		&& PHASE_ALARM == 3'b000 && MASTER_PHASE_TRIP == 3'b000)
		else $error("master output while stopped");
	apb_ready_a: assert property (access |=> PREADY ##1 !PREADY)
		else $error("ready not a single cycle");
endmodule

// ===== verification/breaker_model.sv
`timescale 1ns/100ps
module breaker_model #(
	parameter int NB = 2
) (
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic [NB-1:0] trip,
	output logic      [NB-1:0] opened
);
	// Stays open until reset; a breaker never recloses by itself
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			opened <= '0;
		else
			opened <= opened | trip;
	end
endmodule

// ===== verification/protection_master_gating_tb.sv
`timescale 1ns/100ps
module protection_master_gating_tb;
	localparam logic [14:0] FULL  = {2'b01, 4'h1, 3'h5, 3'h5, 3'b011};
	localparam logic [14:0] NOCMD = {6'h00, 3'h5, 3'h5, 3'b011};
	logic        core_clk;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        blk_a;
	logic        blk_b;
	logic        cmd_blk;
	logic [11:0] fault;
	logic [3:0]  stg_blk;
	logic        g_alarm;
	logic        g_trip;
	logic        g_ground;
	logic [2:0]  ph_alarm;
	logic [2:0]  ph_trip;
	logic [3:0]  open_req;
	logic [1:0]  brk_trip;
	logic [1:0]  opened;
	logic [14:0] outs;
	logic [31:0] rd;
	logic        err;
	int          num_errors;
	int          n_tests;

	assign outs = {brk_trip, open_req, ph_trip, ph_alarm, g_ground, g_trip,
		g_alarm};

	prot_master #(.NUM_STAGES(4), .NUM_BREAKERS(2)) prot_master_i (
		.CORE_CLK              (core_clk),
		.RESET                 (reset),
		.PSEL                  (psel),
		.PENABLE               (penable),
		.PWRITE                (pwrite),
		.PADDR                 (paddr),
		.PWDATA                (pwdata),
		.PRDATA                (prdata),
		.PREADY                (pready),
		.PSLVERR               (pslverr),
		.EXT_BLOCK_IN_A        (blk_a),
		.EXT_BLOCK_IN_B        (blk_b),
		.TRIP_CMD_EXT_BLOCK_IN (cmd_blk),
		.STAGE_FAULT_IN        (fault),
		.STAGE_BLOCK_IN        (stg_blk),
		.GENERAL_ALARM         (g_alarm),
		.GENERAL_TRIP          (g_trip),
		.GROUND_ALARM          (g_ground),
		.PHASE_ALARM           (ph_alarm),
		.MASTER_PHASE_TRIP     (ph_trip),
		.BREAKER_OPEN_REQUEST  (open_req),
		.BREAKER_TRIP          (brk_trip)
	);

	breaker_model #(.NB(2)) breaker_model_i (
		.clk    (core_clk),
		.reset  (reset),
		.trip   (brk_trip),
		.opened (opened)
	);

	always #4 core_clk = ~core_clk;

	task automatic conclude();
		$display("errors %0d of %0d comparisons", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	// Slave answer time is not assumed; a wait ends on pready or after 20 cycles
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			num_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd, e);
	endtask

	task automatic drive(input logic [11:0] f, input logic a, input logic b,
		input logic c, input logic [3:0] s);
		@(posedge core_clk);
		fault <= f;
		blk_a <= a;
		blk_b <= b;
		cmd_blk <= c;
		stg_blk <= s;
	endtask

	// Sync flops plus the stage and output registers settle well inside ten cycles
	task automatic out_chk(input logic [14:0] e);
		repeat (10) @(posedge core_clk);
		check({17'h0, outs}, {17'h0, e});
	endtask

	function automatic logic [31:0] cfg(input logic [15:0] d,
		input logic [7:0] r, input logic [5:0] b);
		cfg = {d, r, 2'b00, b};
	endfunction

	initial begin
		#40000;
		num_errors++;
		conclude();
	end

	initial begin
		core_clk = 1'b0;
		reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{blk_a, blk_b, cmd_blk, fault, stg_blk} = '0;
		num_errors = 0;
		n_tests = 0;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		rd_chk(8'h00, 32'h0);
		rd_chk(8'h10, 32'h0);
		check({17'h0, outs}, 32'h0);
		apb(1'b1, 8'h1c, 32'hffff_ffff);
		rd_chk(8'h1c, 32'hffff_ff3f);
		rd_chk(8'h20, 32'h0);
		check({31'h0, err}, 32'h1);
		apb(1'b1, 8'h04, 32'hffff_ffff);
		check({31'h0, err}, 32'h0);
		rd_chk(8'h04, 32'h0001_0000);
		apb(1'b1, 8'h10, cfg(16'd0, 8'h01, 6'h21));
		apb(1'b1, 8'h14, cfg(16'd6, 8'h02, 6'h11));
		apb(1'b1, 8'h18, cfg(16'd0, 8'h01, 6'h03));
		apb(1'b1, 8'h1c, cfg(16'd0, 8'h02, 6'h00));
		drive(12'h005, 1'b0, 1'b0, 1'b0, 4'h0);
		out_chk(15'h0);
		apb(1'b1, 8'h00, 32'h1);
		out_chk(FULL);
		rd_chk(8'h04, 32'h0000_0553);
		rd_chk(8'h08, 32'h0000_0101);
		check({30'h0, opened}, 32'h1);
		apb(1'b1, 8'h00, 32'h5);
		out_chk(NOCMD);
		apb(1'b1, 8'h00, 32'h1);
		drive(12'h005, 1'b0, 1'b0, 1'b1, 4'h0);
		out_chk(FULL);
		apb(1'b1, 8'h00, 32'h9);
		out_chk(NOCMD);
		drive(12'h005, 1'b0, 1'b0, 1'b0, 4'h0);
		out_chk(FULL);
		apb(1'b1, 8'h00, 32'h3);
		drive(12'h005, 1'b1, 1'b0, 1'b0, 4'h0);
		out_chk(15'h0);
		drive(12'h005, 1'b0, 1'b1, 1'b0, 4'h0);
		out_chk(15'h0);
		drive(12'h005, 1'b0, 1'b0, 1'b0, 4'h0);
		out_chk(FULL);
		apb(1'b1, 8'h00, 32'h0);
		out_chk(15'h0);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h10, cfg(16'd0, 8'h01, 6'h25));
		out_chk(NOCMD);
		apb(1'b1, 8'h10, cfg(16'd0, 8'h01, 6'h29));
		drive(12'h005, 1'b0, 1'b0, 1'b0, 4'h1);
		out_chk(NOCMD);
		drive(12'h005, 1'b0, 1'b0, 1'b0, 4'h0);
		out_chk(FULL);
		drive(12'h040, 1'b0, 1'b0, 1'b0, 4'h0);
		out_chk(15'h0);
		drive(12'h200, 1'b0, 1'b0, 1'b0, 4'h0);
		out_chk(15'h0);
		check({30'h0, opened}, 32'h1);
		// Drop the fault just after the delay runs out: a short trip follows, then alarm and trip clear
		drive(12'h008, 1'b0, 1'b0, 1'b0, 4'h0);
		repeat (7) @(posedge core_clk);
		check({29'h0, g_alarm, g_ground, g_trip}, 32'h6);
		drive(12'h000, 1'b0, 1'b0, 1'b0, 4'h0);
		repeat (12) @(posedge core_clk);
		check({30'h0, g_alarm, g_trip}, 32'h0);
		drive(12'h008, 1'b0, 1'b0, 1'b0, 4'h0);
		repeat (16) @(posedge core_clk);
		check({25'h0, g_trip, open_req, brk_trip}, 32'h4a);
		check({30'h0, opened}, 32'h3);
		conclude();
	end
endmodule
